// *** ipo_pkg.sv ***
// package: register map, fields and types of the input/power/output control bank
package ipo_pkg;

  // register indices and byte addresses
  localparam logic [7:0] IDX_INPUT_POWER  = 8'h1E;
  localparam logic [7:0] IDX_OUT_FORMAT   = 8'h1F;
  localparam logic [7:0] IDX_CLK_SYNC     = 8'h20;
  localparam logic [7:0] IDX_ACTIVITY     = 8'h24;
  localparam int         ADDR_SHIFT       = 2;
  localparam logic [7:0] ADDR_INPUT_POWER = 8'(IDX_INPUT_POWER << ADDR_SHIFT);
  localparam logic [7:0] ADDR_OUT_FORMAT  = 8'(IDX_OUT_FORMAT << ADDR_SHIFT);
  localparam logic [7:0] ADDR_CLK_SYNC    = 8'(IDX_CLK_SYNC << ADDR_SHIFT);
  localparam logic [7:0] ADDR_ACTIVITY    = 8'(IDX_ACTIVITY << ADDR_SHIFT);

  // reset values
  localparam logic [7:0] RST_INPUT_POWER  = 8'h20;
  localparam logic [7:0] RST_OUT_FORMAT   = 8'h94;
  localparam logic [7:0] RST_CLK_SYNC     = 8'h08;

  // input and power control fields
  localparam int B_CH_OVERRIDE = 7;
  localparam int B_CH_SELECT   = 6;
  localparam int B_BW_HIGH     = 5;
  localparam int B_PD_AUTO     = 4;
  localparam int B_PD_BIT      = 3;
  localparam int B_PD_POL      = 2;
  localparam int B_PD_FAST     = 1;
  localparam int B_SOG_PD_HIZ  = 0;
  // output format fields
  localparam int B_MODE_HI     = 7;
  localparam int B_MODE_LO     = 5;
  localparam int B_PRI_EN      = 4;
  localparam int B_SEC_EN      = 3;
  localparam int B_DRV_HI      = 2;
  localparam int B_DRV_LO      = 1;
  localparam int B_CLK_INV     = 0;
  // clock and sync select fields
  localparam int B_CLK_SEL_HI  = 7;
  localparam int B_CLK_SEL_LO  = 6;
  localparam int B_ALL_HIZ     = 5;
  localparam int B_SOG_HIZ     = 4;
  localparam int B_FIELD_POL   = 3;
  localparam int B_PLL_FILT    = 2;
  localparam int B_REGEN_SYNC  = 1;
  // activity status bits: horizontal sync 0/1, green sync 0/1
  localparam int B_ACT_HS0     = 7;
  localparam int B_ACT_HS1     = 6;
  localparam int B_ACT_SOG0    = 3;
  localparam int B_ACT_SOG1    = 2;

  // output modes
  localparam logic [2:0] MODE_444     = 3'h4;
  localparam logic [2:0] MODE_422     = 3'h5;
  localparam logic [2:0] MODE_444_DDR = 3'h6;

  // activity detect window
  localparam int CLK_MHZ        = 50;
  localparam int ACT_WINDOW_US  = 50;
  localparam int ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_MHZ;
  localparam int ACT_CNT_W      = 12;

  typedef enum logic [1:0] {IPO_ST_IDLE, IPO_ST_ANSWER} ipo_bus_e;

  // control lines toward converters, clocking and output pins
  typedef struct packed {
    logic       active_channel;
    logic       high_bandwidth;
    logic       core_power_down;
    logic       red_oe;
    logic       green_oe;
    logic       blue_oe;
    logic       ctrl_oe;
    logic       sync_on_green_output_oe;
    logic       ddr_data;
    logic       blue_secondary;
    logic [1:0] drive_strength;
    logic       clk_invert;
    logic [1:0] clk_select;
    logic       field_out;
    logic       pll_filtered;
    logic       sync_regen;
  } ipo_ctrl_s;

endpackage

// *** ipo_regs.sv ***
// input selection, power-down and output control register bank
// Notes on behaviour
// - bit 7 of input/power: 0 chip picks channel, 1 user bit decides; resets 0.
// - with override, bit 6 selects channel 0 or channel 1; resets 0.
// - bit 5 selects low (0) or high (1) analog bandwidth; resets 1.
// - bit 4 set: auto power-down, stay up while any sync activity shows.
// - manual mode: bit 3 forces power-down; normal only if bit and pin inactive.
// - bit 2 sets power-down pin active level: 0 low, 1 high.
// - bit 1 set: power-down keeps core running, only outputs go high impedance.
// - bit 0 set: green sync output goes high impedance during power-down.
// - format bits 7:5: 100 RGB 4:4:4, 101 YCbCr 4:2:2, 110 DDR; reset 100.
// - 4:2:2 uses 20 pins instead of 30; DDR changes data on both edges.
// - format bit 4 enables primary output; resets 1.
// - in 4:2:2 or DDR blue pins carry secondary DDR; bit 3 enables; resets 0.
// - bits 2:1 drive strength 00 low, 01 medium, 1x high; resets 10.
// - bit 0 inverts output pixel clock; resets 0.
// - clock bits 7:6 choose pixel, 90 degree, double or half clock; resets 00.
// - bit 5 puts every output except green sync output high impedance.
// - bit 4 puts green sync output high impedance; resets 0.
// - bit 3 field encoding: 0 odd high, 1 even high; resets 1.
// - bit 2 feeds the PLL raw (0) or filtered (1) sync; resets 0.
// - bit 1 sync processing uses raw (0) or regenerated (1) sync.
// - activity status bit reads 1 only if its input toggled in the last completed detect window.
//
// Register access over Avalon-MM is this design's own decision.
module ipo_regs (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                power_down_pin,
  input  wire logic [1:0]          horizontal_sync_input,
  input  wire logic [1:0]          green_sync_input,
  input  wire logic                field_is_odd,
  output ipo_pkg::ipo_ctrl_s       ctrl
);
  import ipo_pkg::*;

  logic [7:0]           reg_input_power;
  logic [7:0]           reg_out_format;
  logic [7:0]           reg_clk_sync;
  logic [7:0]           activity;
  logic [3:0]           sync_in;
  logic [3:0]           sync_prev;
  logic [3:0]           seen;
  logic [ACT_CNT_W-1:0] win_cnt;
  logic                 win_end;
  logic                 auto_channel;
  logic                 next_channel;
  logic                 pd_pin_active;
  logic                 pd_request;
  logic                 out_off;
  logic [2:0]           mode;
  logic                 split_mode;
  logic                 wr_take;
  logic                 rd_take;
  logic [7:0]           rd_mux;
  ipo_bus_e             bus_state;
  ipo_ctrl_s            next_ctrl;

  // bus slave: waitrequest drops one cycle after a request, for one cycle
  assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_take = avs_read && avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state       <= IPO_ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_state)
        IPO_ST_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state       <= IPO_ST_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        IPO_ST_ANSWER: begin
          bus_state       <= IPO_ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= IPO_ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (avs_address)
      ADDR_INPUT_POWER: rd_mux = reg_input_power;
      ADDR_OUT_FORMAT:  rd_mux = reg_out_format;
      ADDR_CLK_SYNC:    rd_mux = reg_clk_sync;
      ADDR_ACTIVITY:    rd_mux = activity;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take && bus_state == IPO_ST_IDLE) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // control registers, written at the edge where waitrequest is seen low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_input_power <= RST_INPUT_POWER;
      reg_out_format  <= RST_OUT_FORMAT;
      reg_clk_sync    <= RST_CLK_SYNC;
    end else if (wr_take) begin
      unique case (avs_address)
        ADDR_INPUT_POWER: reg_input_power <= avs_writedata[7:0];
        ADDR_OUT_FORMAT:  reg_out_format  <= avs_writedata[7:0];
        ADDR_CLK_SYNC:    reg_clk_sync    <= avs_writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  // activity detect: a bit is set only if its input changed within the window
  assign sync_in = {horizontal_sync_input, green_sync_input};
  assign win_end = (win_cnt == ACT_CNT_W'(ACT_WINDOW_CYC - 1));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt <= '0;
    end else if (win_end) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + ACT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev <= 4'h0;
    end else begin
      sync_prev <= sync_in;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_act
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        seen[i] <= 1'b0;
      end else if (win_end) begin
        seen[i] <= 1'b0;
      end else if (sync_in[i] != sync_prev[i]) begin
        seen[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      activity <= 8'h00;
    end else if (win_end) begin
      activity[B_ACT_HS0]  <= seen[2] || (sync_in[2] != sync_prev[2]);
      activity[B_ACT_HS1]  <= seen[3] || (sync_in[3] != sync_prev[3]);
      activity[B_ACT_SOG0] <= seen[0] || (sync_in[0] != sync_prev[0]);
      activity[B_ACT_SOG1] <= seen[1] || (sync_in[1] != sync_prev[1]);
    end
  end

  // automatic channel choice: prefer an active channel 0, else active channel 1
  always_comb begin
    next_channel = auto_channel;
    if (activity[B_ACT_HS0] || activity[B_ACT_SOG0]) begin
      next_channel = 1'b0;
    end else if (activity[B_ACT_HS1] || activity[B_ACT_SOG1]) begin
      next_channel = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      auto_channel <= 1'b0;
    end else begin
      auto_channel <= next_channel;
    end
  end

  // power-down decision
  assign pd_pin_active = (power_down_pin == reg_input_power[B_PD_POL]);
  always_comb begin
    if (reg_input_power[B_PD_AUTO]) begin
      pd_request = !(|{activity[B_ACT_HS0], activity[B_ACT_HS1],
                       activity[B_ACT_SOG0], activity[B_ACT_SOG1]});
    end else begin
      pd_request = reg_input_power[B_PD_BIT] || pd_pin_active;
    end
  end

  assign mode       = reg_out_format[B_MODE_HI:B_MODE_LO];
  assign split_mode = (mode == MODE_422) || (mode == MODE_444_DDR);
  assign out_off    = reg_clk_sync[B_ALL_HIZ] || pd_request;

  always_comb begin
    next_ctrl = '0;
    next_ctrl.active_channel = reg_input_power[B_CH_OVERRIDE] ?
                               reg_input_power[B_CH_SELECT] : auto_channel;
    next_ctrl.high_bandwidth  = reg_input_power[B_BW_HIGH];
    next_ctrl.core_power_down = pd_request && !reg_input_power[B_PD_FAST];
    next_ctrl.red_oe   = reg_out_format[B_PRI_EN] && !out_off;
    next_ctrl.green_oe = reg_out_format[B_PRI_EN] && !out_off;
    // blue is secondary in 4:2:2 and DDR, dropping to 20 pins when off
    next_ctrl.blue_oe  = !out_off && (split_mode ? reg_out_format[B_SEC_EN]
                                                 : reg_out_format[B_PRI_EN]);
    next_ctrl.ctrl_oe  = !out_off;
    next_ctrl.sync_on_green_output_oe = !reg_clk_sync[B_SOG_HIZ] &&
        !(pd_request && reg_input_power[B_SOG_PD_HIZ]);
    next_ctrl.ddr_data       = (mode == MODE_444_DDR);
    next_ctrl.blue_secondary = split_mode;
    next_ctrl.drive_strength = reg_out_format[B_DRV_HI:B_DRV_LO];
    next_ctrl.clk_invert     = reg_out_format[B_CLK_INV];
    next_ctrl.clk_select     = reg_clk_sync[B_CLK_SEL_HI:B_CLK_SEL_LO];
    next_ctrl.field_out      = field_is_odd ^ reg_clk_sync[B_FIELD_POL];
    next_ctrl.pll_filtered   = reg_clk_sync[B_PLL_FILT];
    next_ctrl.sync_regen     = reg_clk_sync[B_REGEN_SYNC];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // assertions
  property p_wait_one;
    @(posedge clk_sys) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not one-cycle answer");

  property p_write_lands;
    @(posedge clk_sys) disable iff (!rst_b)
    wr_take && avs_address == ADDR_OUT_FORMAT |=> reg_out_format == $past(avs_writedata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("format write lost");

  property p_override;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_input_power[B_CH_OVERRIDE] |=> ctrl.active_channel == $past(reg_input_power[B_CH_SELECT]);
  endproperty
  a_override: assert property (p_override) else $error("channel override ignored");

  property p_manual_pd;
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_input_power[B_PD_AUTO] && reg_input_power[B_PD_BIT] && !reg_input_power[B_PD_FAST]
      |=> ctrl.core_power_down;
  endproperty
  a_manual_pd: assert property (p_manual_pd) else $error("manual power-down missed");

  property p_auto_up;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_input_power[B_PD_AUTO] && activity[B_ACT_SOG1] |=> !ctrl.core_power_down;
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("auto mode powered down with activity");

  property p_fast_switch;
    @(posedge clk_sys) disable iff (!rst_b)
    pd_request && reg_input_power[B_PD_FAST] |=> !ctrl.core_power_down && !ctrl.red_oe;
  endproperty
  a_fast_switch: assert property (p_fast_switch) else $error("fast switch wrong");

  property p_global_hiz;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_clk_sync[B_ALL_HIZ] |=> !(ctrl.red_oe || ctrl.green_oe || ctrl.blue_oe || ctrl.ctrl_oe);
  endproperty
  a_global_hiz: assert property (p_global_hiz) else $error("outputs drive under global hiz");

  property p_field;
    @(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> ctrl.field_out == ($past(field_is_odd) ^ $past(reg_clk_sync[B_FIELD_POL]));
  endproperty
  a_field: assert property (p_field) else $error("field encoding wrong");

  property p_steady_inactive;
    @(posedge clk_sys) disable iff (!rst_b)
    win_end && !seen[0] && $stable(sync_in[0]) |=> !activity[B_ACT_SOG0];
  endproperty
  a_steady_inactive: assert property (p_steady_inactive) else $error("steady input flagged");

  property p_sog_hiz;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_clk_sync[B_SOG_HIZ] |=> !ctrl.sync_on_green_output_oe;
  endproperty
  a_sog_hiz: assert property (p_sog_hiz) else $error("green sync output drives");

  property p_manual_run;
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_input_power[B_PD_AUTO] && !reg_input_power[B_PD_BIT] &&
      (power_down_pin != reg_input_power[B_PD_POL]) |=> !ctrl.core_power_down;
  endproperty
  a_manual_run: assert property (p_manual_run) else $error("idle pin powered down");

  property p_pin_level;
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_input_power[B_PD_AUTO] && !reg_input_power[B_PD_FAST] &&
      (power_down_pin == reg_input_power[B_PD_POL]) |=> ctrl.core_power_down;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("active pin ignored");

  property p_sog_pd;
    @(posedge clk_sys) disable iff (!rst_b)
    pd_request && reg_input_power[B_SOG_PD_HIZ] |=> !ctrl.sync_on_green_output_oe;
  endproperty
  a_sog_pd: assert property (p_sog_pd) else $error("green sync drives when down");

  property p_primary_off;
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_out_format[B_PRI_EN] |=> !ctrl.red_oe && !ctrl.green_oe;
  endproperty
  a_primary_off: assert property (p_primary_off) else $error("primary drives");

  property p_secondary_off;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_out_format[B_MODE_HI:B_MODE_LO] == MODE_422 && !reg_out_format[B_SEC_EN]
      |=> !ctrl.blue_oe && ctrl.blue_secondary;
  endproperty
  a_secondary_off: assert property (p_secondary_off) else $error("secondary on");

  property p_ddr;
    @(posedge clk_sys) disable iff (!rst_b)
    reg_out_format[B_MODE_HI:B_MODE_LO] == MODE_444_DDR
      |=> ctrl.ddr_data && ctrl.blue_secondary;
  endproperty
  a_ddr: assert property (p_ddr) else $error("double rate mode not set");

  property p_clk_out;
    @(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> ctrl.clk_select == $past(reg_clk_sync[B_CLK_SEL_HI:B_CLK_SEL_LO]) &&
      ctrl.clk_invert == $past(reg_out_format[B_CLK_INV]);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("output clock choice wrong");

  property p_activity_set;
    @(posedge clk_sys) disable iff (!rst_b)
    win_end && seen[2] |=> activity[B_ACT_HS0];
  endproperty
  a_activity_set: assert property (p_activity_set) else $error("toggling input missed");

endmodule // ipo_regs

// *** ipo_display_model.sv ***
// display controller model: reports which output groups it sees driven
module ipo_display_model (
  input  wire ipo_pkg::ipo_ctrl_s ctrl,
  output logic [4:0]              driven
);
  import ipo_pkg::*;

  // red, green, blue, control, green sync; undriven pins read as released
  assign driven = {ctrl.red_oe, ctrl.green_oe, ctrl.blue_oe, ctrl.ctrl_oe,
                   ctrl.sync_on_green_output_oe};
endmodule // ipo_display_model

// *** ipo_regs_tb.sv ***
// self-checking testbench of the input, power and output control bank
module ipo_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ipo_pkg::*;
  logic        clk_sys = 0;
  logic        rst_b = 0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        power_down_pin = 1;
  logic [1:0]  horizontal_sync_input = 2'h0;
  logic [1:0]  green_sync_input = 2'h0;
  logic        field_is_odd = 1;
  ipo_ctrl_s   ctrl;
  logic [4:0]  driven;
  logic [31:0] rd_val;
  logic [1:0]  sync_run = 2'h0;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  ipo_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_down_pin(power_down_pin),
    .horizontal_sync_input(horizontal_sync_input), .green_sync_input(green_sync_input),
    .field_is_odd(field_is_odd), .ctrl(ctrl));
  ipo_display_model disp (.ctrl(ctrl), .driven(driven));

  always #10 clk_sys = ~clk_sys;

  // sync activity source and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    horizontal_sync_input[0] <= horizontal_sync_input[0] ^ sync_run[0];
    green_sync_input[1] <= green_sync_input[1] ^ sync_run[1];
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= 1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_read <= 0;
  endtask

  // let the write land in ctrl
  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    rd(ADDR_INPUT_POWER); chk("input_power", 32'h20, rd_val);
    rd(ADDR_OUT_FORMAT); chk("out_format", 32'h94, rd_val);
    rd(ADDR_CLK_SYNC); chk("clk_sync", 32'h08, rd_val);
    chk("driven", 5'h1F, driven);
    chk("drive", 2'b10, ctrl.drive_strength);
    chk("field", 1'b0, ctrl.field_out);
    chk("bandwidth", 1'b1, ctrl.high_bandwidth);
    chk("clk_inv_reset", 1'b0, ctrl.clk_invert);
    chk("pll_raw", 1'b0, ctrl.pll_filtered);
    chk("channel_reset", 1'b0, ctrl.active_channel);
    $display("done reset values");
  endtask

  task automatic t_bus;
    rd(8'h00); chk("unmapped", 32'h0, rd_val);
    wr(ADDR_OUT_FORMAT, 8'h00, 4'h0);
    rd(ADDR_OUT_FORMAT); chk("no_byte_enable", 32'h94, rd_val);
    wr(ADDR_ACTIVITY, 8'hFF);
    rd(ADDR_ACTIVITY); chk("status_read_only", 32'h0, rd_val);
    $display("done bus refusals");
  endtask

  task automatic t_channel;
    wr(ADDR_INPUT_POWER, 8'hE0); settle();
    chk("channel", 1'b1, ctrl.active_channel);
    wr(ADDR_INPUT_POWER, 8'h80); settle();
    chk("channel", 1'b0, ctrl.active_channel);
    chk("bandwidth", 1'b0, ctrl.high_bandwidth);
    rd(ADDR_INPUT_POWER); chk("readback", 32'h80, rd_val);
    $display("done channel select");
  endtask

  task automatic pd_case(input logic [7:0] d, input logic pin, input logic core,
                         input logic [4:0] drv);
    power_down_pin <= pin;
    wr(ADDR_INPUT_POWER, d); settle();
    chk("core_pd", core, ctrl.core_power_down);
    chk("driven", drv, driven);
  endtask

  task automatic t_power;
    pd_case(8'h08, 1'b1, 1'b1, 5'h01);
    pd_case(8'h04, 1'b1, 1'b1, 5'h01);
    pd_case(8'h04, 1'b0, 1'b0, 5'h1F);
    pd_case(8'h00, 1'b0, 1'b1, 5'h01);
    pd_case(8'h0A, 1'b1, 1'b0, 5'h01);
    pd_case(8'h09, 1'b1, 1'b1, 5'h00);
    pd_case(8'h04, 1'b0, 1'b0, 5'h1F);
    $display("done manual power-down");
  endtask

  task automatic t_format;
    wr(ADDR_OUT_FORMAT, 8'h90); settle();
    chk("ddr_444", 1'b0, ctrl.ddr_data);
    chk("driven_444", 5'h1F, driven);
    chk("drive_low", 2'b00, ctrl.drive_strength);
    chk("secondary_444", 1'b0, ctrl.blue_secondary);
    wr(ADDR_OUT_FORMAT, 8'hB3); settle();
    chk("secondary_422", 1'b1, ctrl.blue_secondary);
    chk("driven_422", 5'h1B, driven);
    chk("drive_med", 2'b01, ctrl.drive_strength);
    chk("clk_inv", 1'b1, ctrl.clk_invert);
    wr(ADDR_OUT_FORMAT, 8'hDC); settle();
    chk("ddr", 1'b1, ctrl.ddr_data);
    chk("secondary_ddr", 1'b1, ctrl.blue_secondary);
    chk("driven_ddr", 5'h1F, driven);
    chk("drive_high", 2'b10, ctrl.drive_strength);
    wr(ADDR_OUT_FORMAT, 8'h86); settle();
    chk("primary_off", 5'h03, driven);
    chk("drive_1x", 1'b1, ctrl.drive_strength[1]);
    wr(ADDR_OUT_FORMAT, 8'hF0); settle();
    chk("undefined_ddr", 1'b0, ctrl.ddr_data);
    chk("undefined_driven", 5'h1F, driven);
    $display("done output format");
  endtask

  task automatic t_clock;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLK_SYNC, {i[1:0], 6'h09}); settle();
      chk("clk_select", i[1:0], ctrl.clk_select);
    end
    wr(ADDR_OUT_FORMAT, 8'hD8);
    wr(ADDR_CLK_SYNC, 8'h29); settle();
    chk("all_hiz", 5'h01, driven);
    wr(ADDR_CLK_SYNC, 8'h11); settle();
    chk("sog_hiz", 5'h1E, driven);
    chk("field_odd", 1'b1, ctrl.field_out);
    field_is_odd <= 0;
    wr(ADDR_CLK_SYNC, 8'h07); settle();
    chk("field_even", 1'b0, ctrl.field_out);
    chk("pll_filt", 1'b1, ctrl.pll_filtered);
    chk("regen", 1'b1, ctrl.sync_regen);
    $display("done clock and sync select");
  endtask

  task automatic t_auto;
    wr(ADDR_INPUT_POWER, 8'h18);
    sync_run <= 2'b10;
    repeat (2 * ACT_WINDOW_CYC + 100) @(posedge clk_sys);
    rd(ADDR_ACTIVITY); chk("activity_ch1", 32'h04, rd_val);
    chk("auto_channel_1", 1'b1, ctrl.active_channel);
    chk("auto_up_ch1", 1'b0, ctrl.core_power_down);
    sync_run <= 2'b11;
    repeat (2 * ACT_WINDOW_CYC + 100) @(posedge clk_sys);
    rd(ADDR_ACTIVITY); chk("activity", 32'h84, rd_val);
    chk("auto_up", 1'b0, ctrl.core_power_down);
    chk("auto_channel_0", 1'b0, ctrl.active_channel);
    sync_run <= 2'b00;
    repeat (2 * ACT_WINDOW_CYC + 100) @(posedge clk_sys);
    rd(ADDR_ACTIVITY); chk("idle", 32'h00, rd_val);
    chk("auto_down", 1'b1, ctrl.core_power_down);
    $display("done automatic power-down");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    t_reset();
    t_bus();
    t_channel();
    t_power();
    t_format();
    t_clock();
    t_auto();
    stop_test();
  end
endmodule // ipo_regs_tb
